// ==== logic/sid_defines.svh ====
`ifndef SID_DEFINES_SVH
`define SID_DEFINES_SVH
// ==========================================
// Opcodes
`define SID_OP_RESET      8'hc0
`define SID_OP_READ       8'h03
`define SID_OP_WRITE      8'h02
`define SID_OP_RTS_BASE   5'h10
`define SID_OP_STATUS     8'ha0
`define SID_OP_BITMOD     8'h05
// ==========================================
// Register file geometry and reset values
`define SID_REG_DEPTH     128
`define SID_TXCTRL0_ADDR  7'h30
`define SID_TXCTRL1_ADDR  7'h40
`define SID_TXCTRL2_ADDR  7'h50
`define SID_TRANSMIT_REQUEST_FLAG_BIT     3
`define SID_INTF_ADDR     7'h2c
`define SID_CTRL_ADDR     4'hf
`define SID_CTRL_RESET    8'he7
`define SID_STAT_ADDR     4'he
`define SID_STAT_RESET    8'h80
// ==========================================
// Timing
`define SID_RESET_HOLD    128
`define SID_SCK_HALF_DIV  5
`endif

// ==== logic/sid_pkg.sv ====
package sid_pkg;
  typedef enum logic [2:0] {
    SID_ST_OPCODE = 3'b000,
    SID_ST_ADDR   = 3'b001,
    SID_ST_READ   = 3'b010,
    SID_ST_WRITE  = 3'b011,
    SID_ST_MASK   = 3'b100,
    SID_ST_DATA   = 3'b101,
    SID_ST_STATUS = 3'b110,
    SID_ST_IGNORE = 3'b111
  } sid_state_t;
endpackage

// ==== logic/sid_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Serial link between host and device
interface sid_link_if;
  logic cs_n; // Chip select, active low
  logic sck;  // Serial clock
  logic si;   // Host to device data
  logic so;   // Device to host data
  modport device (input cs_n, input sck, input si, output so);
  modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

// ==== logic/sid_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sid_defines.svh"
module sid_device
  import sid_pkg::*;
#(
  parameter int RESET_HOLD = `SID_RESET_HOLD
) (
  input  wire logic    sys_clk,      // Oscillator clock
  input  wire logic    rst_n,        // Hardware reset pin, active low
  sid_link_if.device   link,         // Serial link
  output logic         in_reset,     // Device held in reset
  output logic [2:0]   tx_pending,   // Transmit request flags per buffer
  output logic [7:0]   ctrl_reg_out  // Control register contents
);
  // Hold counter is eight bits wide, so longer holds cannot be served
  if (RESET_HOLD < 1 || RESET_HOLD > 255) begin : g_hold_check
    $error("RESET_HOLD out of range");
  end

  // ==========================================
  // Pin synchronisers
  logic [1:0] cs_sync_reg;
  logic [1:0] sck_sync_reg;
  logic [1:0] si_sync_reg;
  logic       sck_prev_reg;
  logic       cs_n_s;
  logic       sck_rise;
  logic       sck_fall;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg  <= 2'h3;
      sck_sync_reg <= 2'h0;
      si_sync_reg  <= 2'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[0], link.cs_n};
      sck_sync_reg <= {sck_sync_reg[0], link.sck};
      si_sync_reg  <= {si_sync_reg[0], link.si};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  // Edges taken only from second stage
  assign cs_n_s   = cs_sync_reg[1];
  assign sck_rise = !cs_n_s && sck_sync_reg[1] && !sck_prev_reg;
  assign sck_fall = !cs_n_s && !sck_sync_reg[1] && sck_prev_reg;

  // ==========================================
  // Reset hold counter, shared by pin and soft reset
  logic [7:0] hold_cnt_reg;
  logic       soft_rst_req;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= 8'(RESET_HOLD);
    end else if (soft_rst_req) begin
      hold_cnt_reg <= 8'(RESET_HOLD);
    end else if (hold_cnt_reg != 8'h00) begin
      hold_cnt_reg <= hold_cnt_reg - 8'h01;
    end
  end
  assign in_reset = hold_cnt_reg != 8'h00;

  // ==========================================
  // Shift engine and command decoder
  sid_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shin_reg;
  logic [7:0] shout_reg;
  logic [6:0] ptr_reg;
  logic [7:0] mask_reg;
  logic       is_bitmod_reg;
  logic       reset_op_reg;
  logic       op_is_read_reg;
  logic [7:0] byte_in;
  logic       byte_done;
  logic [7:0] regs [0:`SID_REG_DEPTH-1];
  logic [7:0] status_byte;

  assign byte_in   = {shin_reg[6:0], si_sync_reg[1]};
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
  // Reset opcode acts only once select rises
  assign soft_rst_req = reset_op_reg && cs_n_s;

  // Status bits gathered from transmit flags and interrupt flags
  assign status_byte = {regs[`SID_TXCTRL2_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT], regs[`SID_INTF_ADDR][4],
                        regs[`SID_TXCTRL1_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT], regs[`SID_INTF_ADDR][3],
                        regs[`SID_TXCTRL0_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT], regs[`SID_INTF_ADDR][2],
                        regs[`SID_INTF_ADDR][1:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= SID_ST_OPCODE;
      bit_cnt_reg   <= 3'h0;
      shin_reg      <= 8'h00;
      ptr_reg       <= 7'h00;
      mask_reg      <= 8'h00;
      is_bitmod_reg <= 1'b0;
      reset_op_reg  <= 1'b0;
    end else if (cs_n_s || in_reset) begin
      // Deselect drops any partial byte
      state_reg    <= SID_ST_OPCODE;
      bit_cnt_reg  <= 3'h0;
      reset_op_reg <= 1'b0;
    end else if (sck_rise) begin
      shin_reg    <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        case (state_reg)
          SID_ST_OPCODE: begin
            is_bitmod_reg <= (byte_in == `SID_OP_BITMOD);
            if (byte_in == `SID_OP_READ || byte_in == `SID_OP_WRITE ||
                byte_in == `SID_OP_BITMOD) begin
              state_reg <= SID_ST_ADDR;
            end else if (byte_in == `SID_OP_STATUS) begin
              state_reg <= SID_ST_STATUS;
            end else if (byte_in == `SID_OP_RESET) begin
              reset_op_reg <= 1'b1;
              state_reg    <= SID_ST_IGNORE;
            end else begin
              state_reg <= SID_ST_IGNORE;
            end
          end
          SID_ST_ADDR: begin
            ptr_reg <= byte_in[6:0];
            if (is_bitmod_reg) begin
              state_reg <= SID_ST_MASK;
            end else begin
              state_reg <= (op_is_read_reg) ? SID_ST_READ : SID_ST_WRITE;
            end
          end
          SID_ST_MASK: begin
            mask_reg  <= byte_in;
            state_reg <= SID_ST_DATA;
          end
          SID_ST_DATA: begin
            state_reg <= SID_ST_IGNORE;
          end
          SID_ST_READ, SID_ST_WRITE: begin
            ptr_reg <= ptr_reg + 7'h01;
          end
          default: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  // Remember read versus write across the address byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_is_read_reg <= 1'b0;
    end else if (byte_done && state_reg == SID_ST_OPCODE) begin
      op_is_read_reg <= (byte_in == `SID_OP_READ);
    end
  end

  // ==========================================
  // Output shifter: load on byte boundary, shift on falling edge
  logic so_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shout_reg <= 8'h00;
      so_reg    <= 1'b0;
    end else if (cs_n_s || in_reset) begin
      // Held low through a soft reset hold, as after the pin
      shout_reg <= 8'h00;
      so_reg    <= 1'b0;
    end else if (byte_done) begin
      // Next byte to send is staged before its first falling edge
      if (state_reg == SID_ST_ADDR && op_is_read_reg && !is_bitmod_reg) begin
        shout_reg <= regs[byte_in[6:0]];
      end else if (state_reg == SID_ST_READ) begin
        shout_reg <= regs[ptr_reg + 7'h01];
      end else if (state_reg == SID_ST_OPCODE && byte_in == `SID_OP_STATUS ||
                   state_reg == SID_ST_STATUS) begin
        shout_reg <= status_byte;
      end else begin
        shout_reg <= 8'h00;
      end
    end else if (sck_fall) begin
      so_reg    <= shout_reg[7];
      shout_reg <= {shout_reg[6:0], 1'b0};
    end
  end
  assign link.so = so_reg;

  // ==========================================
  // Register file writes; transmit requests and bit modify
  logic [6:0] txctrl_addr [0:2];
  assign txctrl_addr[0] = `SID_TXCTRL0_ADDR;
  assign txctrl_addr[1] = `SID_TXCTRL1_ADDR;
  assign txctrl_addr[2] = `SID_TXCTRL2_ADDR;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SID_REG_DEPTH; i++) begin
        regs[i] <= 8'h00;
        if (i[3:0] == `SID_CTRL_ADDR) regs[i] <= `SID_CTRL_RESET;
        if (i[3:0] == `SID_STAT_ADDR) regs[i] <= `SID_STAT_RESET;
      end
    end else if (in_reset) begin
      // Defaults restored throughout the hold, as with the pin
      for (int i = 0; i < `SID_REG_DEPTH; i++) begin
        regs[i] <= 8'h00;
        if (i[3:0] == `SID_CTRL_ADDR) regs[i] <= `SID_CTRL_RESET;
        if (i[3:0] == `SID_STAT_ADDR) regs[i] <= `SID_STAT_RESET;
      end
    end else if (byte_done) begin
      if (state_reg == SID_ST_WRITE) begin
        regs[ptr_reg] <= byte_in;
      end else if (state_reg == SID_ST_DATA) begin
        regs[ptr_reg] <= (regs[ptr_reg] & ~mask_reg) |
                         (byte_in & mask_reg);
      end else if (state_reg == SID_ST_OPCODE && byte_in[7:3] == `SID_OP_RTS_BASE) begin
        // A zero select field falls through every branch below
        for (int b = 0; b < 3; b++) begin
          if (byte_in[b]) regs[txctrl_addr[b]][`SID_TRANSMIT_REQUEST_FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  assign tx_pending   = {regs[`SID_TXCTRL2_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT],
                         regs[`SID_TXCTRL1_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT],
                         regs[`SID_TXCTRL0_ADDR][`SID_TRANSMIT_REQUEST_FLAG_BIT]};
  assign ctrl_reg_out = regs[7'h0f];
endmodule
`default_nettype wire

// ==== logic/sid_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sid_defines.svh"
// ==========================================
// Host end: SPI master mode 0,0 sending one framed command
module sid_host
  import sid_pkg::*;
#(
  parameter int MAX_BYTES = 8,
  parameter int HALF_DIV  = `SID_SCK_HALF_DIV
) (
  input  wire logic                  sys_clk,    // System clock
  input  wire logic                  rst_n,      // Reset, active low
  sid_link_if.host                   link,       // Serial link
  input  wire logic                  cmd_valid,  // Start a transaction
  output logic                       cmd_ready,  // Idle, may take a command
  input  wire logic [3:0]            cmd_len,    // Bytes in the frame, 1..MAX_BYTES
  input  wire logic [MAX_BYTES*8-1:0] cmd_data,  // Byte 0 in the low bits
  output logic                       rx_valid,   // One-cycle pulse per byte in
  output logic [7:0]                 rx_byte,    // Byte returned on SO
  output logic                       done        // One-cycle pulse at frame end
);
  // Byte counter is four bits wide
  if (MAX_BYTES < 1 || MAX_BYTES > 15) begin : g_bytes_check
    $error("MAX_BYTES out of range");
  end
  // Below three cycles a phase, SO cannot settle before it is taken
  if (HALF_DIV < 3 || HALF_DIV > 255) begin : g_div_check
    $error("HALF_DIV out of range");
  end

  // ==========================================
  // Synchroniser for SO
  logic [1:0] so_sync_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) so_sync_reg <= 2'h0;
    else        so_sync_reg <= {so_sync_reg[0], link.so};
  end

  // ==========================================
  // Frame sequencer; clock made by a divider
  logic                   busy_reg;
  logic                   sck_reg;
  logic [7:0]             div_reg;
  logic [2:0]             bit_reg;
  logic [3:0]             byte_reg;
  logic [3:0]             len_reg;
  logic [MAX_BYTES*8-1:0] tx_reg;
  logic [7:0]             rx_reg;
  logic                   tick;

  assign tick      = busy_reg && (div_reg == 8'(HALF_DIV - 1));
  assign cmd_ready = !busy_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      sck_reg  <= 1'b0;
      div_reg  <= 8'h00;
      bit_reg  <= 3'h0;
      byte_reg <= 4'h0;
      len_reg  <= 4'h0;
      tx_reg   <= '0;
      rx_reg   <= 8'h00;
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
      done     <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      done     <= 1'b0;
      div_reg  <= tick ? 8'h00 : (busy_reg ? div_reg + 8'h01 : 8'h00);
      if (!busy_reg && cmd_valid) begin
        // Order of bytes is the caller's; bit modify is opcode, address, mask, data
        busy_reg <= 1'b1;
        tx_reg   <= cmd_data;
        len_reg  <= (cmd_len == 4'h0) ? 4'h1 : cmd_len;
        bit_reg  <= 3'h0;
        byte_reg <= 4'h0;
      end else if (tick) begin
        sck_reg <= !sck_reg;
        // Rising edge needs nothing here: the device samples SI on it
        if (sck_reg) begin
          // SO passes two synchroniser pairs and returns too late for the
          // rising edge, so it is taken at the end of the high phase
          rx_reg  <= {rx_reg[6:0], so_sync_reg[1]};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            rx_byte  <= {rx_reg[6:0], so_sync_reg[1]};
            rx_valid <= 1'b1;
            tx_reg   <= tx_reg >> 8;
            byte_reg <= byte_reg + 4'h1;
            if (byte_reg + 4'h1 == len_reg) begin
              busy_reg <= 1'b0;
              done     <= 1'b1;
            end
          end
        end
      end
    end
  end

  // SI is the current byte's next bit, msb first
  assign link.si   = tx_reg[7 - bit_reg];
  assign link.sck  = sck_reg;
  assign link.cs_n = !busy_reg;
endmodule
`default_nettype wire

// ==== testbench/sid_link_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sid_defines.svh"
// ==========================================
// Link and reset checks beside the interface
module sid_link_asserts #(
  parameter int RESET_HOLD = 128
) (
  input wire logic       sys_clk,      // Clock
  input wire logic       rst_n,        // Reset, active low
  input wire logic       cs_n,         // Chip select
  input wire logic       sck,          // Serial clock
  input wire logic       si,           // Host data
  input wire logic       so,           // Device data
  input wire logic       in_reset,     // Device reset hold
  input wire logic [2:0] tx_pending,   // Transmit flags
  input wire logic [7:0] ctrl_reg_out  // Control register
);
  logic [8:0] hold_cnt_reg;
  logic [7:0] bits_reg;
  logic       sck_prev_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Helpers
  // Length of the current reset hold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hold_cnt_reg <= '0;
    else if (in_reset) hold_cnt_reg <= hold_cnt_reg + 9'h001;
    else hold_cnt_reg <= '0;
  end

  // Serial clock rises within a frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sck_prev_reg <= 1'b0;
    else sck_prev_reg <= sck;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bits_reg <= '0;
    else if (cs_n) bits_reg <= '0;
    else if (sck && !sck_prev_reg) bits_reg <= bits_reg + 8'h01;
  end

  // Reset held over two samples, so defaults have landed
  sequence s_held;
    in_reset ##1 in_reset;
  endsequence

  // ==========================================
  // Properties
  a_cs_setup: assert property ($fell(cs_n) |-> !sck [*4])
    else $error("serial clock moved too soon after select");
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("serial clock runs outside a frame");
  a_si_stable: assert property ($rose(sck) |-> $stable(si))
    else $error("host data moved at the sampling edge");
  a_so_on_low: assert property ($changed(so) && !cs_n |-> !sck)
    else $error("device data moved while serial clock high");
  a_byte_whole: assert property ($rose(cs_n) |-> bits_reg[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_reset_hold: assert property ($fell(in_reset) |->
    hold_cnt_reg >= RESET_HOLD && hold_cnt_reg <= RESET_HOLD + 1)
    else $error("reset hold has the wrong length");
  a_reset_defaults: assert property (s_held |-> tx_pending == 3'h0 &&
    ctrl_reg_out == `SID_CTRL_RESET && !so)
    else $error("registers not at defaults during reset");
  a_tx_in_frame: assert property ($changed(tx_pending) |-> !cs_n || in_reset)
    else $error("transmit flags moved outside a command");
endmodule
`default_nettype wire

// ==== testbench/test_spi_instruction_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sid_defines.svh"
module test_spi_instruction_decoder;
  // Short hold keeps the run brief
  localparam int HOLD = 8;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cmd_len   = 4'h1;
  logic [63:0] cmd_data  = '0;
  logic        cmd_ready;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        done;
  logic        in_reset;
  logic [2:0]  tx_pending;
  logic [7:0]  ctrl_reg_out;
  logic [7:0]  si_sh     = '0;
  logic [7:0]  rx_q[$];
  int          err_total = 0;
  int          checks    = 0;

  // ==========================================
  // Ends joined across the link
  sid_link_if i_sid_link_if ();
  sid_device #(.RESET_HOLD(HOLD)) i_sid_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(i_sid_link_if), .in_reset(in_reset), .tx_pending(tx_pending),
    .ctrl_reg_out(ctrl_reg_out));
  sid_host i_sid_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(i_sid_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_len(cmd_len), .cmd_data(cmd_data),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .done(done));
  sid_link_asserts #(.RESET_HOLD(HOLD)) i_sid_link_asserts (.sys_clk(sys_clk),
    .rst_n(rst_n), .cs_n(i_sid_link_if.cs_n), .sck(i_sid_link_if.sck),
    .si(i_sid_link_if.si), .so(i_sid_link_if.so), .in_reset(in_reset),
    .tx_pending(tx_pending), .ctrl_reg_out(ctrl_reg_out));

  // ==========================================
  // Clock, byte capture and wire watch
  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) if (rx_valid === 1'b1) rx_q.push_back(rx_byte);

  // Bits as the device samples them, last byte kept
  always @(posedge i_sid_link_if.sck) si_sh = {si_sh[6:0], i_sid_link_if.si};

  // ==========================================
  // Tasks
  task automatic oops(input string what);
    err_total++;
    $display("Error at %0t: %s", $time, what);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One whole frame; gap after it lets the device resync
  task automatic send(input logic [3:0] len, input logic [63:0] data);
    int n;
    n = 0;
    rx_q.delete();
    @(negedge sys_clk);
    cmd_len   = len;
    cmd_data  = data;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000) oops("frame never finished");
    repeat (5) @(negedge sys_clk);
  endtask

  task automatic settle;
    int n;
    n = 0;
    while (in_reset !== 1'b0 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 1000) oops("reset hold never ended");
  endtask

  task automatic soft_reset;
    send(4'h1, 64'h00c0);
    chk({7'h00, in_reset}, 8'h01, "hold after reset opcode");
    settle();
    chk(ctrl_reg_out, `SID_CTRL_RESET, "control default");
    chk({5'h00, tx_pending}, 8'h00, "flags cleared");
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    settle();
    chk(ctrl_reg_out, `SID_CTRL_RESET, "control after pin reset");
    chk({5'h00, tx_pending}, 8'h00, "flags after pin reset");
    $display("test power_on done");
    send(4'h5, {24'h0, 24'h332211, 8'h20, 8'h02});
    send(4'h6, {48'h0, 8'h20, 8'h03});
    for (int i = 0; i < 3; i++) begin
      chk(rx_q[i+2], 8'(17 * (i + 1)), "read back");
    end
    send(4'h3, {40'h0, 8'h85, 8'h0f, 8'h02});
    chk(ctrl_reg_out, 8'h85, "control written");
    $display("test write_read done");
    send(4'h4, {32'h0, 8'h5a, 8'hf0, 8'h0f, 8'h05});
    chk(ctrl_reg_out, 8'h55, "masked update");
    // Tail looks like a write; it must be swallowed
    send(4'h4, {32'h0, 8'h00, 8'h0f, 8'h02, 8'h42});
    chk(ctrl_reg_out, 8'h55, "unknown opcode ignored");
    $display("test modify_unknown done");
    for (int n = 0; n < 8; n++) begin
      soft_reset();
      send(4'h1, {56'h0, 5'h10, n[2:0]});
      chk(si_sh, {5'h10, n[2:0]}, "wire bit order");
      chk({5'h00, tx_pending}, {5'h00, n[2:0]}, "transmit flags");
    end
    send(4'h3, {40'h0, 8'h00, 8'h30, 8'h03});
    chk({7'h00, rx_q[2][`SID_TRANSMIT_REQUEST_FLAG_BIT]}, 8'h01, "flag in buffer control");
    $display("test transmit_request done");
    send(4'h3, {56'h0, 8'ha0});
    chk(rx_q[1], 8'ha8, "status byte");
    chk(rx_q[2], 8'ha8, "status repeated");
    $display("test status done");
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    oops("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
